// File: core/lcrc_clk_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lcrc_clk_if;
  logic init_tick;
  logic clkgen_unlocked_s;
  logic clkgen_locked;

  modport ctl (
    output init_tick,
    output clkgen_unlocked_s,
    input  clkgen_locked
  );

  modport mon (
    input  init_tick,
    input  clkgen_unlocked_s,
    output clkgen_locked
  );
endinterface
`default_nettype wire

// File: core/lcrc_clkgen_mon.sv
`timescale 1ns/1ps
`default_nettype none
module lcrc_clkgen_mon (
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  lcrc_clk_if.mon   clk_if
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       locked;
  } lcrc_mon_regs_t;

  lcrc_mon_regs_t r;
  lcrc_mon_regs_t next_r;

  // Sampled on the free-running init tick only, so a stalled transceiver clock cannot fake lock
  always_comb begin
    next_r = r;
    if (clk_if.init_tick) begin
      if (clk_if.clkgen_unlocked_s) begin
        next_r.cnt    = '0;
        next_r.locked = 1'b0;
      end else if (r.cnt == 4'(lcrc_pkg::LOCK_STABLE_TICKS - 1)) begin
        next_r.locked = 1'b1;
      end else begin
        next_r.cnt = r.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign clk_if.clkgen_locked = r.locked;

  AST_CLKGEN_DROP: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (clk_if.init_tick && clk_if.clkgen_unlocked_s) |=> !clk_if.clkgen_locked)
    else $error("clock generator lock kept after unlock sample");
endmodule
`default_nettype wire

// File: core/lcrc_pkg.sv
`default_nettype none
package lcrc_pkg;

  // ----------------------------------------------------------------
  // Clock rates and timing
  // ----------------------------------------------------------------
  localparam int unsigned REF_PERIOD_NS    = 25;
  localparam int unsigned INIT_TICK_NS     = 100;
  localparam int unsigned INIT_DIV_CYC     = (INIT_TICK_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int unsigned SYNC_DIV_DEFAULT = 2;
  localparam int unsigned INT_WIDTH_NARROW = 32;
  localparam int unsigned EXT_WIDTH_BITS   = 64;

  // ----------------------------------------------------------------
  // Datapath byte widths
  // ----------------------------------------------------------------
  localparam logic [3:0] TX_PATH_BYTES    = 4'h8;
  localparam logic [3:0] RX_BYTES_NARROW  = 4'h4;
  localparam logic [3:0] RX_BYTES_WIDE    = 4'h8;

  // ----------------------------------------------------------------
  // Counts
  // ----------------------------------------------------------------
  localparam int unsigned CORE_RST_HOLD_USER = 128;
  localparam int unsigned LOCK_STABLE_TICKS  = 6;
  localparam int unsigned LANE_LOCK_GOOD     = 4;
  localparam int unsigned LANE_LOCK_BAD      = 2;

  // ----------------------------------------------------------------
  // Pin synchroniser bit positions
  // ----------------------------------------------------------------
  localparam int unsigned IN_CORE_RST = 0;
  localparam int unsigned IN_XCVR_RST = 1;
  localparam int unsigned IN_PWRDN    = 2;
  localparam int unsigned IN_UNLOCKED = 3;
  localparam int unsigned IN_XCVR_OK  = 4;
  localparam int unsigned IN_VALID    = 5;
  localparam int unsigned IN_BOND     = 6;
  localparam int unsigned IN_CCOMP    = 7;
  localparam int unsigned IN_NUM      = 8;

  typedef enum logic [1:0] {
    LCRC_RESET,
    LCRC_LANE_INIT,
    LCRC_BOND,
    LCRC_UP
  } lcrc_state_t;

endpackage
`default_nettype wire

// File: core/lcrc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module lcrc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lcrc_sync_regs_t;

  lcrc_sync_regs_t r;
  lcrc_sync_regs_t next_r;

  // First stage feeds only the second stage
  always_comb begin
    next_r    = r;
    next_r.s1 = d_i;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q_o = r.s2;
endmodule
`default_nettype wire

// File: core/lcrc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Three phase-locked clock enables from one divider
// - User clock feeds fabric port, sync feeds first
// - Clock-generator lock sampled on init clock
// - Eight-byte transmit, four- or eight-byte receive
// - Clock ratios follow internal and external widths
// - Core reset aborts and restarts channel init
// - Lock dropped while partner sends no patterns
// - One core reset clears transmit and receive
// - Full transceiver reset also resets core
// - Bonding and compensation on recovered clock enable
// - Power-down resets core, transceiver stays powered
module lcrc_top #(
  parameter int unsigned INT_WIDTH = lcrc_pkg::INT_WIDTH_NARROW,
  parameter int unsigned SYNC_DIV  = lcrc_pkg::SYNC_DIV_DEFAULT
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       core_link_reset_i,
  input  wire logic       xcvr_full_reset_i,
  input  wire logic       power_down_i,
  input  wire logic       clkgen_unlocked_i,
  input  wire logic       xcvr_reset_done_i,
  input  wire logic       partner_pattern_valid_i,
  input  wire logic       lane_bonding_pattern_i,
  input  wire logic       clock_compensation_word_i,
  output logic            xcvr_tx_fabric_clock_en_o,
  output logic            xcvr_tx_user_clock_en_o,
  output logic            tx_out_clock_en_o,
  output logic            xcvr_reset_o,
  output logic            xcvr_powered_o,
  output logic            tx_reset_o,
  output logic            rx_reset_o,
  output logic            send_patterns_o,
  output logic            lane_lock_o,
  output logic            channel_up_o,
  output logic            init_restart_o,
  output logic            clock_compensation_seen_o,
  output logic [3:0]      tx_path_bytes_o,
  output logic [3:0]      rx_path_bytes_o
);
  // ----------------------------------------------------------------
  // Derived rates
  // ----------------------------------------------------------------
  localparam int unsigned RATIO       = lcrc_pkg::EXT_WIDTH_BITS / INT_WIDTH;
  localparam int          USER_PERIOD = int'(RATIO * SYNC_DIV);
  localparam logic [3:0]  RX_BYTES    = (INT_WIDTH == lcrc_pkg::INT_WIDTH_NARROW) ?
                                        lcrc_pkg::RX_BYTES_NARROW : lcrc_pkg::RX_BYTES_WIDE;

  typedef struct packed {
    lcrc_pkg::lcrc_state_t st;
    logic [7:0]            sync_cnt;
    logic [7:0]            phase;
    logic [7:0]            init_cnt;
    logic                  init_tick;
    logic [7:0]            hold_cnt;
    logic [2:0]            good_cnt;
    logic [1:0]            bad_cnt;
    logic                  user_en;
    logic                  sync_en;
    logic                  txout_en;
    logic                  xcvr_reset;
    logic                  xcvr_powered;
    logic                  tx_reset;
    logic                  rx_reset;
    logic                  send_patterns;
    logic                  lane_lock;
    logic                  channel_up;
    logic                  init_restart;
    logic                  cc_seen;
    logic [3:0]            tx_bytes;
    logic [3:0]            rx_bytes;
  } lcrc_regs_t;

  lcrc_regs_t r;
  lcrc_regs_t next_r;

  logic [lcrc_pkg::IN_NUM-1:0] pins;
  logic [lcrc_pkg::IN_NUM-1:0] pins_s;
  logic                        s_core_rst;
  logic                        s_pma;
  logic                        s_pwrdn;
  logic                        s_xcvr_ok;
  logic                        s_valid;
  logic                        s_bond;
  logic                        s_ccomp;
  logic                        any_rst;

  lcrc_clk_if clk_if ();

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  assign pins = {clock_compensation_word_i, lane_bonding_pattern_i, partner_pattern_valid_i,
                 xcvr_reset_done_i, clkgen_unlocked_i, power_down_i, xcvr_full_reset_i,
                 core_link_reset_i};

  lcrc_sync #(
    .W (lcrc_pkg::IN_NUM)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .d_i       (pins),
    .q_o       (pins_s)
  );

  assign s_core_rst = pins_s[lcrc_pkg::IN_CORE_RST];
  assign s_pma      = pins_s[lcrc_pkg::IN_XCVR_RST];
  assign s_pwrdn    = pins_s[lcrc_pkg::IN_PWRDN];
  assign s_xcvr_ok  = pins_s[lcrc_pkg::IN_XCVR_OK];
  assign s_valid    = pins_s[lcrc_pkg::IN_VALID];
  assign s_bond     = pins_s[lcrc_pkg::IN_BOND];
  assign s_ccomp    = pins_s[lcrc_pkg::IN_CCOMP];

  // Active-high unlocked input, i.e. the inverted PLL lock
  assign clk_if.clkgen_unlocked_s = pins_s[lcrc_pkg::IN_UNLOCKED];
  assign clk_if.init_tick         = r.init_tick;

  lcrc_clkgen_mon u_mon (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .clk_if    (clk_if)
  );

  // Power-down and a lost clock generator reset the core like the core reset does
  assign any_rst = s_core_rst | s_pma | s_pwrdn | !clk_if.clkgen_locked;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r              = r;
    next_r.init_restart = 1'b0;
    next_r.cc_seen      = 1'b0;

    // One divider makes every parallel rate, so the enables stay phase-locked
    if (r.sync_cnt == 8'(SYNC_DIV - 1)) begin
      next_r.sync_cnt = '0;
      next_r.phase    = (r.phase == 8'(RATIO - 1)) ? 8'h00 : r.phase + 8'h01;
    end else begin
      next_r.sync_cnt = r.sync_cnt + 8'h01;
    end
    next_r.sync_en  = (next_r.sync_cnt == 8'h00);
    next_r.txout_en = next_r.sync_en;
    next_r.user_en  = next_r.sync_en && (next_r.phase == 8'h00);

    // Free-running init tick, independent of any reset cause
    next_r.init_tick = (r.init_cnt == 8'(lcrc_pkg::INIT_DIV_CYC - 1));
    next_r.init_cnt  = next_r.init_tick ? 8'h00 : r.init_cnt + 8'h01;

    next_r.xcvr_reset   = s_pma;
    next_r.xcvr_powered = 1'b1;
    next_r.tx_bytes     = lcrc_pkg::TX_PATH_BYTES;
    next_r.rx_bytes     = RX_BYTES;

    // Lane lock follows the partner's patterns on the recovered-clock tick
    if (r.st == lcrc_pkg::LCRC_RESET) begin
      next_r.lane_lock = 1'b0;
      next_r.good_cnt  = '0;
      next_r.bad_cnt   = '0;
    end else if (r.sync_en) begin
      if (s_valid) begin
        next_r.bad_cnt = '0;
        if (r.good_cnt == 3'(lcrc_pkg::LANE_LOCK_GOOD - 1)) begin
          next_r.lane_lock = 1'b1;
        end else begin
          next_r.good_cnt = r.good_cnt + 3'h1;
        end
      end else begin
        next_r.good_cnt = '0;
        if (r.bad_cnt == 2'(lcrc_pkg::LANE_LOCK_BAD - 1)) begin
          next_r.lane_lock = 1'b0;
        end else begin
          next_r.bad_cnt = r.bad_cnt + 2'h1;
        end
      end
      next_r.cc_seen = s_ccomp;
    end

    if (any_rst) begin
      next_r.st        = lcrc_pkg::LCRC_RESET;
      next_r.hold_cnt  = 8'(lcrc_pkg::CORE_RST_HOLD_USER - 1);
      next_r.lane_lock = 1'b0;
    end else begin
      unique case (r.st)
        lcrc_pkg::LCRC_RESET: begin
          // Hold counts user ticks, so the user clock must already run
          if (r.user_en) begin
            if (r.hold_cnt != 8'h00) begin
              next_r.hold_cnt = r.hold_cnt - 8'h01;
            end else if (s_xcvr_ok) begin
              next_r.st           = lcrc_pkg::LCRC_LANE_INIT;
              next_r.init_restart = 1'b1;
            end
          end
        end
        lcrc_pkg::LCRC_LANE_INIT: begin
          if (r.lane_lock) begin
            next_r.st = lcrc_pkg::LCRC_BOND;
          end
        end
        lcrc_pkg::LCRC_BOND: begin
          if (!r.lane_lock) begin
            next_r.st = lcrc_pkg::LCRC_LANE_INIT;
          end else if (r.sync_en && s_bond) begin
            next_r.st = lcrc_pkg::LCRC_UP;
          end
        end
        lcrc_pkg::LCRC_UP: begin
          if (!r.lane_lock) begin
            next_r.st           = lcrc_pkg::LCRC_LANE_INIT;
            next_r.init_restart = 1'b1;
          end
        end
      endcase
    end

    // A single reset state clears both halves
    next_r.tx_reset      = (next_r.st == lcrc_pkg::LCRC_RESET);
    next_r.rx_reset      = (next_r.st == lcrc_pkg::LCRC_RESET);
    next_r.send_patterns = (next_r.st != lcrc_pkg::LCRC_RESET);
    next_r.channel_up    = (next_r.st == lcrc_pkg::LCRC_UP);
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r          <= '0;
      r.tx_reset <= 1'b1;
      r.rx_reset <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign xcvr_tx_fabric_clock_en_o = r.user_en;
  assign xcvr_tx_user_clock_en_o   = r.sync_en;
  assign tx_out_clock_en_o         = r.txout_en;
  assign xcvr_reset_o              = r.xcvr_reset;
  assign xcvr_powered_o            = r.xcvr_powered;
  assign tx_reset_o                = r.tx_reset;
  assign rx_reset_o                = r.rx_reset;
  assign send_patterns_o           = r.send_patterns;
  assign lane_lock_o               = r.lane_lock;
  assign channel_up_o              = r.channel_up;
  assign init_restart_o            = r.init_restart;
  assign clock_compensation_seen_o = r.cc_seen;
  assign tx_path_bytes_o           = r.tx_bytes;
  assign rx_path_bytes_o           = r.rx_bytes;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_USER_PHASE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    r.user_en |-> (r.sync_en && r.txout_en))
    else $error("user enable not aligned to sync enable");

  AST_USER_PERIOD: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    r.user_en |-> ##USER_PERIOD r.user_en)
    else $error("user enable period wrong");

  AST_WIDTHS: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    $rose(r.sync_en) |-> (r.tx_bytes == lcrc_pkg::TX_PATH_BYTES && r.rx_bytes == RX_BYTES))
    else $error("datapath byte widths wrong");

  AST_CORE_RESET: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    s_core_rst |=> (r.st == lcrc_pkg::LCRC_RESET && !r.channel_up && !r.send_patterns))
    else $error("core reset did not abort operation");

  AST_BOTH_HALVES: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    s_core_rst |=> (r.tx_reset && r.rx_reset))
    else $error("core reset missed one half");

  AST_FULL_RESET: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    s_pma |=> (r.xcvr_reset && r.tx_reset))
    else $error("full reset did not reset core");

  AST_POWER_DOWN: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (s_pwrdn && !s_pma) |=> (r.tx_reset && r.xcvr_powered && !r.xcvr_reset))
    else $error("power-down touched the transceiver");

  AST_LOCK_DROP: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (r.sync_en && !s_valid && r.bad_cnt == 2'(lcrc_pkg::LANE_LOCK_BAD - 1)) |=> !r.lane_lock)
    else $error("lock kept without partner patterns");

  AST_RESTART: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (r.st == lcrc_pkg::LCRC_UP && !r.lane_lock && !any_rst) |=>
      (r.init_restart && r.st == lcrc_pkg::LCRC_LANE_INIT))
    else $error("lock loss did not restart init");

  AST_BOND_TICK: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (r.st == lcrc_pkg::LCRC_BOND && !any_rst && !(r.sync_en && s_bond) && r.lane_lock) |=>
      (r.st == lcrc_pkg::LCRC_BOND))
    else $error("bonding left without recovered-clock pattern");

  AST_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (r.st == lcrc_pkg::LCRC_RESET && r.hold_cnt != 8'h00) |=> (r.st == lcrc_pkg::LCRC_RESET))
    else $error("reset released before hold ended");
endmodule
`default_nettype wire

// File: verification/lcrc_partner_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far channel partner: sends lane patterns only while told to, on every reference clock cycle
module lcrc_partner_model (
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  input  wire logic send_i,
  input  wire logic bond_i,
  input  wire logic comp_i,
  output logic      pattern_valid_o,
  output logic      bonding_o,
  output logic      comp_o
);
  logic [3:0] gap;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap             <= 4'h0;
      pattern_valid_o <= 1'b0;
      bonding_o       <= 1'b0;
      comp_o          <= 1'b0;
    end else begin
      gap             <= gap + 4'h1;
      // Silence means no valid patterns, so the far side must drop lock
      pattern_valid_o <= send_i;
      bonding_o       <= send_i & bond_i;
      // Two cycles wide so that one sync tick always falls inside it
      comp_o          <= send_i & comp_i & (gap[3:1] == 3'h7);
    end
  end
endmodule
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       ref_clk_i;
  logic       rst_b_i;
  logic       core_link_reset_i;
  logic       xcvr_full_reset_i;
  logic       power_down_i;
  logic       clkgen_unlocked_i;
  logic       xcvr_reset_done_i;
  logic       send;
  logic       bond;
  logic       comp;
  logic       pv;
  logic       bp;
  logic       cw;
  logic       fab_en;
  logic       usr_en;
  logic       txo_en;
  logic       xcvr_reset_o;
  logic       xcvr_powered_o;
  logic       tx_reset_o;
  logic       rx_reset_o;
  logic       send_patterns_o;
  logic       lane_lock_o;
  logic       channel_up_o;
  logic       init_restart_o;
  logic       comp_seen;
  logic [3:0] tx_bytes;
  logic [3:0] rx_bytes;
  int         err_count;
  int         tests_run;
  int         cyc = 0;

  lcrc_top DUT (
    .ref_clk_i                 (ref_clk_i),
    .rst_b_i                   (rst_b_i),
    .core_link_reset_i         (core_link_reset_i),
    .xcvr_full_reset_i         (xcvr_full_reset_i),
    .power_down_i              (power_down_i),
    .clkgen_unlocked_i         (clkgen_unlocked_i),
    .xcvr_reset_done_i         (xcvr_reset_done_i),
    .partner_pattern_valid_i   (pv),
    .lane_bonding_pattern_i    (bp),
    .clock_compensation_word_i (cw),
    .xcvr_tx_fabric_clock_en_o (fab_en),
    .xcvr_tx_user_clock_en_o   (usr_en),
    .tx_out_clock_en_o         (txo_en),
    .xcvr_reset_o              (xcvr_reset_o),
    .xcvr_powered_o            (xcvr_powered_o),
    .tx_reset_o                (tx_reset_o),
    .rx_reset_o                (rx_reset_o),
    .send_patterns_o           (send_patterns_o),
    .lane_lock_o               (lane_lock_o),
    .channel_up_o              (channel_up_o),
    .init_restart_o            (init_restart_o),
    .clock_compensation_seen_o (comp_seen),
    .tx_path_bytes_o           (tx_bytes),
    .rx_path_bytes_o           (rx_bytes)
  );

  lcrc_partner_model u_partner (
    .ref_clk_i       (ref_clk_i),
    .rst_b_i         (rst_b_i),
    .send_i          (send),
    .bond_i          (bond),
    .comp_i          (comp),
    .pattern_valid_o (pv),
    .bonding_o       (bp),
    .comp_o          (cw)
  );

  initial ref_clk_i = 1'b0;
  // Runs from time zero and never stops, resets included
  always #12.5 ref_clk_i = ~ref_clk_i;

  // Bring-ups take about 600 cycles each; the ceiling leaves wide margin
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  function automatic logic pick(input int s);
    case (s)
      0:       pick = channel_up_o;
      1:       pick = lane_lock_o;
      2:       pick = tx_reset_o;
      default: pick = init_restart_o;
    endcase
  endfunction

  // Bounded wait, sampled mid-cycle so one-cycle pulses are caught
  task automatic wait_for(input string what, input int s, input logic v, input int n);
    int i;
    i = 0;
    while (pick(s) !== v && i < n) begin
      @(negedge ref_clk_i);
      i++;
    end
    check(what, {7'h0, pick(s)}, {7'h0, v});
  endtask

  task automatic relink;
    wait_for("init_restart", 3, 1'b1, 1500);
    wait_for("channel_up", 0, 1'b1, 80);
  endtask

  task automatic expect_reset(input logic xr);
    repeat (4) @(negedge ref_clk_i);
    check("tx_reset", {7'h0, tx_reset_o}, 8'h01);
    check("rx_reset", {7'h0, rx_reset_o}, 8'h01);
    check("channel_up", {7'h0, channel_up_o}, 8'h00);
    check("send_patterns", {7'h0, send_patterns_o}, 8'h00);
    check("xcvr_reset", {7'h0, xcvr_reset_o}, {7'h0, xr});
    check("powered", {7'h0, xcvr_powered_o}, 8'h01);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_bringup;
    repeat (4) @(negedge ref_clk_i);
    check("tx_reset in reset", {7'h0, tx_reset_o}, 8'h01);
    check("rx_bytes in reset", {4'h0, rx_bytes}, 8'h00);
    @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(negedge ref_clk_i);
    check("tx_bytes", {4'h0, tx_bytes}, 8'h08);
    check("rx_bytes", {4'h0, rx_bytes}, 8'h04);
    check("powered", {7'h0, xcvr_powered_o}, 8'h01);
    repeat (100) @(negedge ref_clk_i);
    check("held while unlocked", {7'h0, tx_reset_o}, 8'h01);
    check("xcvr reset held", {7'h0, xcvr_reset_o}, 8'h01);
    @(posedge ref_clk_i);
    clkgen_unlocked_i <= 1'b0;
    // Full reset stays on until the generator has had time to report lock
    repeat (40) @(posedge ref_clk_i);
    xcvr_full_reset_i <= 1'b0;
    repeat (660) @(negedge ref_clk_i);
    check("held until xcvr done", {7'h0, tx_reset_o}, 8'h01);
    @(posedge ref_clk_i);
    xcvr_reset_done_i <= 1'b1;
    send              <= 1'b1;
    wait_for("init_restart", 3, 1'b1, 100);
    @(negedge ref_clk_i);
    check("tx_reset released", {7'h0, tx_reset_o}, 8'h00);
    check("send_patterns", {7'h0, send_patterns_o}, 8'h01);
    wait_for("lane_lock", 1, 1'b1, 40);
    repeat (40) @(negedge ref_clk_i);
    check("up without bonding", {7'h0, channel_up_o}, 8'h00);
    @(posedge ref_clk_i);
    bond <= 1'b1;
    wait_for("channel_up", 0, 1'b1, 30);
  endtask

  task automatic t_clocks;
    int nf;
    int nu;
    int nt;
    int nd;
    nf = 0;
    nu = 0;
    nt = 0;
    nd = 0;
    repeat (32) begin
      @(negedge ref_clk_i);
      nf += int'(fab_en === 1'b1);
      nu += int'(usr_en === 1'b1);
      nt += int'(txo_en === 1'b1);
      nd += int'(txo_en !== usr_en);
    end
    check("user clock pulses", nf[7:0], 8'h08);
    check("sync clock pulses", nu[7:0], 8'h10);
    check("out clock pulses", nt[7:0], 8'h10);
    check("out vs sync phase", nd[7:0], 8'h00);
  endtask

  task automatic t_core_reset;
    @(posedge ref_clk_i);
    core_link_reset_i <= 1'b1;
    @(negedge ref_clk_i);
    check("reset not yet seen", {7'h0, tx_reset_o}, 8'h00);
    expect_reset(1'b0);
    repeat (20) @(posedge ref_clk_i);
    core_link_reset_i <= 1'b0;
    relink();
  endtask

  task automatic t_lock_loss;
    @(posedge ref_clk_i);
    send <= 1'b0;
    wait_for("lock lost", 1, 1'b0, 20);
    wait_for("channel down", 0, 1'b0, 5);
    repeat (30) @(negedge ref_clk_i);
    check("no lock while silent", {7'h0, lane_lock_o}, 8'h00);
    @(posedge ref_clk_i);
    send <= 1'b1;
    wait_for("channel regained", 0, 1'b1, 80);
  endtask

  task automatic t_comp;
    int n;
    n = 0;
    @(posedge ref_clk_i);
    comp <= 1'b1;
    repeat (64) begin
      @(negedge ref_clk_i);
      n += int'(comp_seen === 1'b1);
    end
    check("comp seen", {7'h0, n != 0}, 8'h01);
    @(posedge ref_clk_i);
    comp <= 1'b0;
    repeat (8) @(negedge ref_clk_i);
    n = 0;
    repeat (40) begin
      @(negedge ref_clk_i);
      n += int'(comp_seen !== 1'b0);
    end
    check("comp quiet", n[7:0], 8'h00);
  endtask

  task automatic t_cause(input int which);
    @(posedge ref_clk_i);
    case (which)
      0:       clkgen_unlocked_i <= 1'b1;
      1:       xcvr_full_reset_i <= 1'b1;
      default: power_down_i      <= 1'b1;
    endcase
    if (which == 0) begin
      wait_for("unlock resets", 2, 1'b1, 40);
    end else begin
      expect_reset(which == 1);
    end
    repeat (20) @(posedge ref_clk_i);
    clkgen_unlocked_i <= 1'b0;
    xcvr_full_reset_i <= 1'b0;
    power_down_i      <= 1'b0;
    relink();
  endtask

  initial begin
    rst_b_i           = 1'b0;
    core_link_reset_i = 1'b0;
    xcvr_full_reset_i = 1'b1;
    power_down_i      = 1'b0;
    clkgen_unlocked_i = 1'b1;
    xcvr_reset_done_i = 1'b0;
    send              = 1'b0;
    bond              = 1'b0;
    comp              = 1'b0;
    err_count         = 0;
    tests_run         = 0;
    t_bringup();
    t_clocks();
    t_core_reset();
    t_lock_loss();
    t_comp();
    t_cause(0);
    t_cause(1);
    t_cause(2);
    end_sim();
  end
endmodule
`default_nettype wire
